// [core/lpm_pkg.sv]
/*
  Package for the low-power mode sequencer and its software-side controller.
  Assumes a single 25 MHz clock domain shared by both ends.
*/
package lpm_pkg;

  localparam logic [2:0] PM_ACTIVE = 3'h0;
  localparam logic [2:0] PM_BACKUP = 3'h4;

  localparam int WAKE_W = 8;
  localparam int WK_PIN = 0;
  localparam int WK_PERIPH = 1;
  localparam int WK_RTC = 2;
  localparam int WK_RESET_PIN = 3;
  localparam int WK_LP_RX = 4;
  localparam int WK_TMR_A = 5;
  localparam int WK_TMR_B = 6;
  localparam int WK_DMA = 7;

  localparam logic [WAKE_W-1:0] WAKE_ALL = 8'hFF;
  localparam logic [WAKE_W-1:0] WAKE_NONE = 8'h00;
  localparam logic [WAKE_W-1:0] MASK_SLEEP = 8'h8B;
  localparam logic [WAKE_W-1:0] MASK_DEEP = 8'h7D;
  localparam logic [WAKE_W-1:0] MASK_STORAGE = 8'h0D;

  localparam int RAM_BLOCKS = 4;
  localparam int RAM_ONE_KB = 16;
  localparam int RAM_TWO_KB = 32;
  localparam int RAM_THREE_KB = 64;

  localparam int SCRATCH_W = 32;
  localparam logic [SCRATCH_W-1:0] SCRATCH_RST = 32'h00000000;

  localparam int SYS_RESET_NS = 200;
  localparam int CLK_NS = 40;
  localparam int SYS_RESET_CYC = (SYS_RESET_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [2:0] {
    ST_ACTIVE = 3'b000,
    ST_SLEEP = 3'b001,
    ST_DEEP = 3'b010,
    ST_BACKUP = 3'b011,
    ST_STORAGE = 3'b100,
    ST_RESTART = 3'b101
  } lpm_state_t;

endpackage

// [core/lpm_if.sv]
/*
  Interface joining the sequencer and the software-side controller.
  Assumes both ends run on sys_clk.
*/
`timescale 1ns/1ps
interface lpm_if;
  import lpm_pkg::*;
  logic core_deep_sleep_select;
  logic wait_instr;
  logic pm_write;
  logic [2:0] power_mode_field;
  logic storage_enable;
  logic vcore_det_bypass;
  logic flash_busy;
  logic wake_status_clear;
  logic lp_wake_status_clear;
  logic [WAKE_W-1:0] wake_status_reg;
  logic [WAKE_W-1:0] lp_periph_wake_status_reg;
  lpm_state_t mode;
  logic reset_vector_restart;

  modport device (
    input core_deep_sleep_select, wait_instr, pm_write, power_mode_field, storage_enable,
    input vcore_det_bypass, flash_busy, wake_status_clear, lp_wake_status_clear,
    output wake_status_reg, lp_periph_wake_status_reg, mode, reset_vector_restart
  );
  modport software (
    output core_deep_sleep_select, wait_instr, pm_write, power_mode_field, storage_enable,
    output vcore_det_bypass, flash_busy, wake_status_clear, lp_wake_status_clear,
    input wake_status_reg, lp_periph_wake_status_reg, mode, reset_vector_restart
  );
endinterface

// [core/low_power_mode_sequencer.sv]
/*
  Device end: power-mode state machine, wake qualification, clock/power gating outputs.
  Assumes wake sources come from other clock domains or pins and are synchronised here.
*/
`timescale 1ns/1ps

// Summary of operation
// - Light sleep wakes on pins, peripherals, reset.
// - Deep sleep/backup wake on RTC, pins, reset, LP.
// - Storage wakes only on RTC, pins, reset.
// - Running mode enables everything; per-peripheral gating.
// - Light sleep stops only processor clock.
// - Pin, peripheral, reset or DMA wake leaves light sleep; DMA usable.
// - Software picks sleep depth by select bit.
// - Deep sleep gates all but nanoring and 32k oscillator; keeps CPU.
// - 32k oscillator kept; watchdogs off in deep/backup.
// - Deep sleep keeps registers, RAM, pin outputs.
// - LP receiver and timers run in deep/backup.
// - Software clears both wake status before entry.
// - Software sets voltage-detector bypass before entry.
// - No flash operation during low-power request.
// - Backup powers off CPU and fast oscillators.
// - Backup keeps sequencer registers; others off.
// - Blocks one to three retained by fields.
// - Block zero never retained across backup.
// - Optional auto-clear of always-on and retention.
// - Mode code 4 enters backup; exit restarts.
// - Storage enable then backup code enters storage.
// - Storage retains no RAM, disables LP parts.
// - Backup/storage exit gives reset, spares LP parts.
module low_power_mode_sequencer
  import lpm_pkg::*;
(
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Software side
  lpm_if.device sw,
  // Raw wake sources
  input wire logic [WAKE_W-1:0] wake_src,
  input wire logic [WAKE_W-1:0] wake_clear_bits,
  // Configuration
  input wire logic [RAM_BLOCKS-1:0] ram_keep_cfg,
  input wire logic auto_clear_aod_cfg,
  input wire logic ertco_en_cfg,
  input wire logic [7:0] periph_en_cfg,
  input wire logic [SCRATCH_W-1:0] scratch_a_wdata,
  input wire logic [SCRATCH_W-1:0] scratch_b_wdata,
  input wire logic scratch_we,
  // Power and clock controls
  output logic cpu_clk_en,
  output logic bus_clk_en,
  output logic always_on_clock_en,
  output logic system_oscillator_en,
  output logic fast_osc_en,
  output logic nanoring_oscillator_en,
  output logic ertco_en,
  output logic watchdog_en,
  output logic cpu_power_en,
  output logic cpu_state_keep,
  output logic dma_en,
  output logic [7:0] periph_clk_en,
  output logic lp_periph_en,
  output logic gpio_hold,
  output logic [RAM_BLOCKS-1:0] ram_keep,
  output logic always_on_domain_clear,
  output logic system_reset_req,
  output logic [SCRATCH_W-1:0] sequencer_scratch_a,
  output logic [SCRATCH_W-1:0] sequencer_scratch_b
);

  lpm_state_t state_r;
  lpm_state_t state_nxt;
  logic [WAKE_W-1:0] sync1_r;
  logic [WAKE_W-1:0] sync2_r;
  logic [WAKE_W-1:0] wake_st_r;
  logic [WAKE_W-1:0] lp_st_r;
  logic [3:0] rst_cnt_r;
  logic restart_r;
  logic [WAKE_W-1:0] allowed;
  logic [WAKE_W-1:0] wake_st_nxt;
  logic [WAKE_W-1:0] lp_st_nxt;

  function automatic logic [WAKE_W-1:0] wake_mask(input lpm_state_t s);
    case (s)
      ST_SLEEP: wake_mask = MASK_SLEEP;
      ST_DEEP: wake_mask = MASK_DEEP;
      ST_BACKUP: wake_mask = MASK_DEEP;
      ST_STORAGE: wake_mask = MASK_STORAGE;
      default: wake_mask = WAKE_NONE;
    endcase
  endfunction

  assign allowed = sync2_r & wake_mask(state_r);

  // Two-flop synchroniser for wake sources.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sync1_r <= WAKE_NONE;
      sync2_r <= WAKE_NONE;
    end else if (clk_en) begin
      sync1_r <= wake_src;
      sync2_r <= sync1_r;
    end
  end

  // Mode transitions.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_ACTIVE: begin
        if (!sw.flash_busy && sw.vcore_det_bypass) begin
          if (sw.pm_write && sw.power_mode_field == PM_BACKUP) begin
            state_nxt = sw.storage_enable ? ST_STORAGE : ST_BACKUP;
          end else if (sw.wait_instr) begin
            state_nxt = sw.core_deep_sleep_select ? ST_DEEP : ST_SLEEP;
          end
        end
      end
      ST_SLEEP, ST_DEEP: begin
        if (|allowed) begin
          state_nxt = ST_ACTIVE;
        end
      end
      ST_BACKUP, ST_STORAGE: begin
        if (|allowed) begin
          state_nxt = ST_RESTART;
        end
      end
      ST_RESTART: begin
        if (rst_cnt_r == 4'(SYS_RESET_CYC - 1)) begin
          state_nxt = ST_ACTIVE;
        end
      end
      default: state_nxt = ST_ACTIVE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_ACTIVE;
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  // Restart timing of the system reset after backup or storage.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_cnt_r <= 4'h0;
      restart_r <= 1'b0;
    end else if (clk_en) begin
      rst_cnt_r <= (state_r == ST_RESTART) ? rst_cnt_r + 4'h1 : 4'h0;
      if (state_r == ST_RESTART && state_nxt == ST_ACTIVE) begin
        restart_r <= 1'b1;
      end else begin
        restart_r <= 1'b0;
      end
    end
  end

  // Sticky wake status; a new event wins over a clear.
  assign wake_st_nxt = (wake_st_r & ~(sw.wake_status_clear ? WAKE_ALL : wake_clear_bits)) | allowed;
  assign lp_st_nxt = (lp_st_r & ~(sw.lp_wake_status_clear ? WAKE_ALL : wake_clear_bits))
                   | (allowed & MASK_DEEP & ~MASK_STORAGE);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wake_st_r <= WAKE_NONE;
      lp_st_r <= WAKE_NONE;
    end else if (clk_en) begin
      wake_st_r <= wake_st_nxt;
      lp_st_r <= lp_st_nxt;
    end
  end

  // Scratch registers are held through every mode.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sequencer_scratch_a <= SCRATCH_RST;
      sequencer_scratch_b <= SCRATCH_RST;
    end else if (clk_en && scratch_we && state_r == ST_ACTIVE) begin
      sequencer_scratch_a <= scratch_a_wdata;
      sequencer_scratch_b <= scratch_b_wdata;
    end
  end

  // Clock and power gating per mode.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cpu_clk_en <= 1'b1;
      bus_clk_en <= 1'b1;
      always_on_clock_en <= 1'b1;
      system_oscillator_en <= 1'b1;
      fast_osc_en <= 1'b1;
      nanoring_oscillator_en <= 1'b1;
      ertco_en <= 1'b0;
      watchdog_en <= 1'b1;
      cpu_power_en <= 1'b1;
      cpu_state_keep <= 1'b1;
      dma_en <= 1'b1;
      periph_clk_en <= 8'h00;
      lp_periph_en <= 1'b1;
      gpio_hold <= 1'b0;
      ram_keep <= 4'h0;
      always_on_domain_clear <= 1'b0;
      system_reset_req <= 1'b0;
      sw.wake_status_reg <= WAKE_NONE;
      sw.lp_periph_wake_status_reg <= WAKE_NONE;
      sw.mode <= ST_ACTIVE;
      sw.reset_vector_restart <= 1'b0;
    end else if (clk_en) begin
      cpu_clk_en <= state_nxt == ST_ACTIVE;
      bus_clk_en <= state_nxt inside {ST_ACTIVE, ST_SLEEP, ST_RESTART};
      system_oscillator_en <= state_nxt inside {ST_ACTIVE, ST_SLEEP, ST_RESTART};
      always_on_clock_en <= state_nxt inside {ST_ACTIVE, ST_SLEEP, ST_RESTART};
      fast_osc_en <= state_nxt inside {ST_ACTIVE, ST_SLEEP, ST_RESTART};
      nanoring_oscillator_en <= 1'b1;
      ertco_en <= ertco_en_cfg;
      watchdog_en <= state_nxt inside {ST_ACTIVE, ST_SLEEP};
      cpu_power_en <= !(state_nxt inside {ST_BACKUP, ST_STORAGE});
      cpu_state_keep <= state_nxt inside {ST_ACTIVE, ST_SLEEP, ST_DEEP};
      dma_en <= state_nxt inside {ST_ACTIVE, ST_SLEEP};
      periph_clk_en <= (state_nxt inside {ST_ACTIVE, ST_SLEEP}) ? periph_en_cfg : 8'h00;
      lp_periph_en <= state_nxt != ST_STORAGE;
      gpio_hold <= state_nxt inside {ST_DEEP, ST_BACKUP, ST_STORAGE};
      case (state_nxt)
        ST_BACKUP: ram_keep <= auto_clear_aod_cfg ? 4'h0 : {ram_keep_cfg[3:1], 1'b0};
        ST_STORAGE: ram_keep <= 4'h0;
        default: ram_keep <= 4'hF;
      endcase
      always_on_domain_clear <= auto_clear_aod_cfg && state_nxt == ST_BACKUP;
      system_reset_req <= state_nxt == ST_RESTART;
      sw.wake_status_reg <= wake_st_nxt;
      sw.lp_periph_wake_status_reg <= lp_st_nxt;
      sw.mode <= state_nxt;
      sw.reset_vector_restart <= restart_r;
    end
  end

endmodule

// [core/lpm_software.sv]
/*
  Software end: issues mode requests over the interface in the documented order.
  Assumes a user command strobe on the same clock.
*/
`timescale 1ns/1ps
module lpm_software
  import lpm_pkg::*;
(
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Interface to the sequencer
  lpm_if.software sw,
  // User commands: 0 sleep, 1 deep, 2 backup, 3 storage
  input wire logic req,
  input wire logic [1:0] req_mode,
  input wire logic flash_busy_in,
  output logic busy,
  output logic [WAKE_W-1:0] last_wake
);

  typedef enum logic [1:0] {
    SW_IDLE = 2'b00,
    SW_CLEAR = 2'b01,
    SW_ENTER = 2'b10,
    SW_WAIT = 2'b11
  } sw_state_t;

  sw_state_t st_r;
  logic [1:0] mode_r;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= SW_IDLE;
      mode_r <= 2'h0;
      busy <= 1'b0;
      last_wake <= WAKE_NONE;
      sw.core_deep_sleep_select <= 1'b0;
      sw.wait_instr <= 1'b0;
      sw.pm_write <= 1'b0;
      sw.power_mode_field <= PM_ACTIVE;
      sw.storage_enable <= 1'b0;
      sw.vcore_det_bypass <= 1'b0;
      sw.flash_busy <= 1'b0;
      sw.wake_status_clear <= 1'b0;
      sw.lp_wake_status_clear <= 1'b0;
    end else if (clk_en) begin
      sw.flash_busy <= flash_busy_in;
      sw.wait_instr <= 1'b0;
      sw.pm_write <= 1'b0;
      sw.wake_status_clear <= 1'b0;
      sw.lp_wake_status_clear <= 1'b0;
      case (st_r)
        SW_IDLE: begin
          busy <= 1'b0;
          if (req && !flash_busy_in) begin
            mode_r <= req_mode;
            busy <= 1'b1;
            st_r <= SW_CLEAR;
          end
        end
        SW_CLEAR: begin
          sw.wake_status_clear <= 1'b1;
          sw.lp_wake_status_clear <= 1'b1;
          sw.vcore_det_bypass <= 1'b1;
          sw.storage_enable <= mode_r == 2'h3;
          sw.core_deep_sleep_select <= mode_r == 2'h1;
          st_r <= SW_ENTER;
        end
        SW_ENTER: begin
          if (mode_r[1]) begin
            sw.pm_write <= 1'b1;
            sw.power_mode_field <= PM_BACKUP;
          end else begin
            sw.wait_instr <= 1'b1;
          end
          st_r <= SW_WAIT;
        end
        SW_WAIT: begin
          if (sw.mode == ST_ACTIVE && !sw.pm_write && !sw.wait_instr) begin
            last_wake <= sw.wake_status_reg;
            sw.storage_enable <= 1'b0;
            busy <= 1'b0;
            st_r <= SW_IDLE;
          end
        end
        default: st_r <= SW_IDLE;
      endcase
    end
  end

endmodule

// [verif/lpm_link_props.sv]
/*
  Checker for the link between the sequencer and the software end.
  Assumes the bench instantiates it beside the lpm_if instance.
*/
`timescale 1ns/1ps
module lpm_link_props
  import lpm_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Link signals
  input wire logic core_deep_sleep_select,
  input wire logic wait_instr,
  input wire logic pm_write,
  input wire logic [2:0] power_mode_field,
  input wire logic storage_enable,
  input wire logic vcore_det_bypass,
  input wire logic flash_busy,
  input wire logic [WAKE_W-1:0] lp_periph_wake_status_reg,
  input wire lpm_state_t mode,
  input wire logic reset_vector_restart
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  wire go = mode == ST_ACTIVE && vcore_det_bypass && !flash_busy;
  wire wfi = go && wait_instr && !pm_write;
  wire pmw = go && pm_write && power_mode_field == PM_BACKUP && !wait_instr;
  wire low = mode == ST_BACKUP || mode == ST_STORAGE;

  a_sleep_entry: assert property (wfi && !core_deep_sleep_select |=> mode == ST_SLEEP)
    else $error("sleep not entered");
  a_deep_entry: assert property (wfi && core_deep_sleep_select |=> mode == ST_DEEP)
    else $error("deep sleep not entered");
  a_backup_entry: assert property (pmw && !storage_enable |=> mode == ST_BACKUP)
    else $error("backup not entered");
  a_storage_entry: assert property (pmw && storage_enable |=> mode == ST_STORAGE)
    else $error("storage not entered");
  a_flash_refused: assert property (mode == ST_ACTIVE && flash_busy |=> mode == ST_ACTIVE)
    else $error("request taken while flash busy");
  a_bypass_refused: assert property (mode == ST_ACTIVE && !vcore_det_bypass |=> mode == ST_ACTIVE)
    else $error("request taken without bypass");
  a_sleep_exit: assert property (mode == ST_SLEEP ##1 mode != ST_SLEEP |-> mode == ST_ACTIVE)
    else $error("sleep left to wrong mode");
  a_deep_exit: assert property (mode == ST_DEEP ##1 mode != ST_DEEP |-> mode == ST_ACTIVE)
    else $error("deep sleep left to wrong mode");
  a_backup_exit: assert property (low ##1 !low |-> mode == ST_RESTART)
    else $error("backup left without restart");
  a_restart_len: assert property ($rose(mode == ST_RESTART) |-> (mode == ST_RESTART) [*5] ##1 mode == ST_ACTIVE)
    else $error("restart length wrong");
  a_restart_pulse: assert property ($rose(reset_vector_restart) |=> !reset_vector_restart)
    else $error("restart pulse too long");
  a_lp_bits_only: assert property ((lp_periph_wake_status_reg & 8'h8F) == 8'h00)
    else $error("lp status has foreign bits");
endmodule

// [verif/tb_low_power_mode_sequencer.sv]
/*
  Self-checking bench: the software end walks the sequencer through every mode.
  Assumes the package, interface and both design ends are compiled first.
*/
`timescale 1ns/1ps
module tb_low_power_mode_sequencer;
  import lpm_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic clk_en = 1'b1;
  logic req = 1'b0;
  logic [1:0] req_mode = 2'h0;
  logic flash_busy_in = 1'b0;
  logic [WAKE_W-1:0] wake_src = 8'h00;
  logic [WAKE_W-1:0] wake_clear_bits = 8'h00;
  logic [RAM_BLOCKS-1:0] ram_keep_cfg = 4'hF;
  logic auto_clear_aod_cfg = 1'b0;
  logic ertco_en_cfg = 1'b1;
  logic [7:0] periph_en_cfg = 8'hA5;
  logic [SCRATCH_W-1:0] sa_w = 32'h00000000;
  logic [SCRATCH_W-1:0] sb_w = 32'h00000000;
  logic scratch_we = 1'b0;
  logic busy, cpu_clk_en, bus_clk_en, system_oscillator_en, nanoring_oscillator_en, watchdog_en;
  logic cpu_power_en, lp_periph_en, ertco_en, always_on_domain_clear, system_reset_req;
  logic always_on_clock_en, fast_osc_en, cpu_state_keep, dma_en, gpio_hold;
  logic [7:0] periph_clk_en;
  logic [WAKE_W-1:0] last_wake;
  logic [RAM_BLOCKS-1:0] ram_keep;
  logic [SCRATCH_W-1:0] sc_a, sc_b;
  int n_fail = 0;
  int cmp_count = 0;
  wire [17:0] gate = {always_on_clock_en, fast_osc_en, cpu_state_keep, dma_en, gpio_hold, always_on_domain_clear,
    cpu_clk_en, bus_clk_en, system_oscillator_en, nanoring_oscillator_en, watchdog_en, cpu_power_en, lp_periph_en,
    ertco_en, ram_keep};

  lpm_if u_lpm_if ();
  low_power_mode_sequencer u_low_power_mode_sequencer (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
    .sw(u_lpm_if), .wake_src(wake_src), .wake_clear_bits(wake_clear_bits), .ram_keep_cfg(ram_keep_cfg),
    .auto_clear_aod_cfg(auto_clear_aod_cfg), .ertco_en_cfg(ertco_en_cfg), .periph_en_cfg(periph_en_cfg),
    .scratch_a_wdata(sa_w), .scratch_b_wdata(sb_w), .scratch_we(scratch_we), .cpu_clk_en(cpu_clk_en),
    .bus_clk_en(bus_clk_en), .always_on_clock_en(always_on_clock_en), .system_oscillator_en(system_oscillator_en),
    .fast_osc_en(fast_osc_en), .nanoring_oscillator_en(nanoring_oscillator_en), .ertco_en(ertco_en),
    .watchdog_en(watchdog_en), .cpu_power_en(cpu_power_en), .cpu_state_keep(cpu_state_keep), .dma_en(dma_en),
    .periph_clk_en(periph_clk_en), .lp_periph_en(lp_periph_en), .gpio_hold(gpio_hold), .ram_keep(ram_keep),
    .always_on_domain_clear(always_on_domain_clear), .system_reset_req(system_reset_req),
    .sequencer_scratch_a(sc_a), .sequencer_scratch_b(sc_b));
  lpm_software u_lpm_software (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .sw(u_lpm_if), .req(req),
    .req_mode(req_mode), .flash_busy_in(flash_busy_in), .busy(busy), .last_wake(last_wake));
  lpm_link_props u_props (.sys_clk(sys_clk), .nrst(nrst),
    .core_deep_sleep_select(u_lpm_if.core_deep_sleep_select), .wait_instr(u_lpm_if.wait_instr),
    .pm_write(u_lpm_if.pm_write), .power_mode_field(u_lpm_if.power_mode_field),
    .storage_enable(u_lpm_if.storage_enable), .vcore_det_bypass(u_lpm_if.vcore_det_bypass),
    .flash_busy(u_lpm_if.flash_busy), .lp_periph_wake_status_reg(u_lpm_if.lp_periph_wake_status_reg),
    .mode(u_lpm_if.mode), .reset_vector_restart(u_lpm_if.reset_vector_restart));

  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Drives wake source src and waits up to 60 cycles for the software end to go idle, counting reset and restart-vector cycles.
  task automatic settle(input int src, output int r, output int v);
    int n;
    r = 0;
    v = 0;
    n = 0;
    wake_src = 8'h01 << src;
    while (busy !== 1'b0 && n < 60) begin
      @(negedge sys_clk);
      r += int'(system_reset_req === 1'b1);
      v += int'(u_lpm_if.reset_vector_restart === 1'b1);
      n++;
    end
    wake_src = 8'h00;
  endtask

  task automatic run(input string name, input logic [1:0] m, input lpm_state_t st, input logic [17:0] exp,
                     input int ign, input int wk, input int rc);
    int n;
    int r;
    int v;
    @(negedge sys_clk);
    req_mode = m;
    req = 1'b1;
    @(negedge sys_clk);
    req = 1'b0;
    n = 0;
    while (u_lpm_if.mode === ST_ACTIVE && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    check(u_lpm_if.mode, st, "entered mode");
    check(gate, exp, "gating");
    wake_src[ign] = 1'b1;
    repeat (6) @(negedge sys_clk);
    check(u_lpm_if.mode, st, "masked wake");
    settle(wk, r, v);
    check(u_lpm_if.mode, ST_ACTIVE, "woken");
    check(r, rc, "reset length");
    check(v, int'(rc != 0), "restart pulse");
    check({last_wake[wk], u_lpm_if.wake_status_reg[wk]}, 2'h3, "wake latch");
    check(u_lpm_if.lp_periph_wake_status_reg[wk], wk inside {[4:6]}, "lp latch");
    check({cpu_clk_en, periph_clk_en}, {1'b1, periph_en_cfg}, "active");
    wake_clear_bits = 8'hFF;
    @(negedge sys_clk);
    wake_clear_bits = 8'h00;
    @(negedge sys_clk);
    check({u_lpm_if.wake_status_reg, u_lpm_if.lp_periph_wake_status_reg}, 16'h0000, "clear");
    $display("Test %s done", name);
  endtask

  initial begin
    repeat (10) @(negedge sys_clk);
    nrst = 1'b1;
    @(negedge sys_clk);
    sa_w = 32'hA5A50001;
    sb_w = 32'h5A5A0002;
    scratch_we = 1'b1;
    @(negedge sys_clk);
    clk_en = 1'b0;
    sa_w = 32'hFFFFFFFF;
    @(negedge sys_clk);
    scratch_we = 1'b0;
    clk_en = 1'b1;
    flash_busy_in = 1'b1;
    req = 1'b1;
    @(negedge sys_clk);
    req = 1'b0;
    repeat (8) @(negedge sys_clk);
    check(u_lpm_if.mode, ST_ACTIVE, "flash busy");
    flash_busy_in = 1'b0;
    req = 1'b1;
    @(negedge sys_clk);
    req = 1'b0;
    flash_busy_in = 1'b1;
    repeat (8) @(negedge sys_clk);
    check({u_lpm_if.mode, busy}, {ST_ACTIVE, 1'b0}, "late flash busy");
    flash_busy_in = 1'b0;
    $display("Test flash_refusal done");
    run("sleep", 2'h0, ST_SLEEP, 18'h3C7FF, 5, 7, 0);
    run("deep", 2'h1, ST_DEEP, 18'h0A17F, 7, 6, 0);
    run("backup", 2'h2, ST_BACKUP, 18'h0213E, 1, 4, SYS_RESET_CYC);
    run("storage", 2'h3, ST_STORAGE, 18'h02110, 4, 2, SYS_RESET_CYC);
    auto_clear_aod_cfg = 1'b1;
    run("backup_clear", 2'h2, ST_BACKUP, 18'h03130, 7, 3, SYS_RESET_CYC);
    auto_clear_aod_cfg = 1'b0;
    check({sc_a, sc_b}, {32'hA5A50001, 32'h5A5A0002}, "scratch kept");
    summarize();
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    summarize();
  end
endmodule
